// File: dv/ws2_bus_rx.sv
// Bus receiver model that counts telegrams.
`timescale 1ns/100ps
`default_nettype none
module ws2_bus_rx (
  input  wire logic aclk,     // Clock.
  input  wire logic aresetn,  // Reset, active low.
  input  wire logic tx_valid, // Strobe.
  input  wire logic tx_bit,   // Value.
  output var  int   rx_n,     // Count.
  output var  logic rx_last   // Last value.
);
  // Takes every one-bit telegram, as the bus never refuses.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_n    <= 0;
      rx_last <= 1'b0;
    end
    else if (tx_valid === 1'b1)
    begin
      rx_n    <= rx_n + 1;
      rx_last <= tx_bit;
    end
  end
endmodule : ws2_bus_rx
`default_nettype wire

// File: dv/ws2_monitor_tb_top.sv
// Testbench of the wind threshold monitor.
`timescale 1ns/100ps
`default_nettype none
module ws2_monitor_tb_top;
  import ws2_pkg::*;
  logic        aclk, aresetn, awv, wv, arv;
  logic [15:0] ws;
  logic [7:0]  awa, ara;
  logic [31:0] wd;
  wire logic   awr, wr, bv, arr, rv, st, txv, txb, rxl;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  int          rxn, fail_count, compares, n0;
  // Clock of 8 ns.
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ws2_monitor #(.TICK_CYCLES(10)) dut (.aclk(aclk), .aresetn(aresetn), .wind_speed(ws),
    .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hF),
    .s_wvalid(wv), .s_wready(wr), .s_bresp(br), .s_bvalid(bv), .s_bready(1'b1),
    .s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rdata(rd), .s_rresp(rr),
    .s_rvalid(rv), .s_rready(1'b1), .state_out(st), .tx_valid(txv), .tx_bit(txb));
  ws2_bus_rx rx (.aclk(aclk), .aresetn(aresetn), .tx_valid(txv), .tx_bit(txb),
    .rx_n(rxn), .rx_last(rxl));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // A wait that runs out of its bound counts as a mismatch and ends the run.
  task automatic tmo(input string nm, input logic ok);
    if (!ok)
    begin
      fail_count++;
      $display("Error %s expected 1 seen 0", nm);
      end_of_test();
    end
  endtask : tmo
  // Bready is held high, so the response is taken when bvalid is seen.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    hb = 1'b0;
    for (int n = 0; n < 50 && !hb; n++)
    begin
      @(negedge aclk);
      ha = awv & awr;
      hw = wv & wr;
      hb = bv;
      r = br;
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end
    tmo("bvalid", hb);
    chk("bresp", 32'(e), 32'(r));
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    hr = 1'b0;
    for (int n = 0; n < 50 && !hr; n++)
    begin
      @(negedge aclk);
      ha = arv & arr;
      hr = rv;
      d = rd;
      r = rr;
      @(posedge aclk);
      if (ha) arv <= 1'b0;
    end
    tmo("rvalid", hr);
    chk("rdata", e, d);
    chk("rresp", 32'(er), 32'(r));
  endtask : rd_reg
  // Sets the speed, then waits for the state and checks the earliest moment.
  task automatic go(input logic [15:0] s, input logic v, input int lo, input int hi);
    int n;
    @(posedge aclk);
    ws <= s;
    for (n = 0; n < hi && st !== v; n++)
      @(negedge aclk);
    tmo("state_out", st === v);
    // One more cycle lets the bus receiver take a telegram sent with the change.
    @(negedge aclk);
    chk("state_out", 32'(v), 32'(st));
    chk("not_early", 1, 32'(n >= lo));
  endtask : go
  task automatic idle(input int c);
    repeat (c) @(negedge aclk);
  endtask : idle
  // Reset values and an unmapped address.
  task automatic t_reset();
    rd_reg(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    rd_reg(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    rd_reg(8'h18, 32'h0, RESP_SLVERR);
    $display("Test reset done");
  endtask : t_reset
  // Fixed threshold with hysteresis on exceeding, then on undershoot with zero hysteresis.
  task automatic t_hyst();
    wr_reg(ADDR_CTRL, 32'h0000_4011, RESP_OKAY);
    n0 = rxn;
    go(16'h001F, 1'b1, 0, 20);
    chk("tx_bit", 1, 32'(rxl));
    go(16'h0019, 1'b1, 0, 20);
    idle(10);
    chk("state_out", 1, 32'(st));
    go(16'h0013, 1'b0, 0, 20);
    chk("telegrams", 2, rxn - n0);
    wr_reg(ADDR_CTRL, 32'h0000_4201, RESP_OKAY);
    go(16'h0013, 1'b1, 0, 20);
    go(16'h001F, 1'b0, 0, 20);
    $display("Test hysteresis done");
  endtask : t_hyst
  // Threshold taken from the two-byte and the percent value.
  task automatic t_ext();
    wr_reg(ADDR_EXT16, 32'h0000_0064, RESP_OKAY);
    wr_reg(ADDR_CTRL, 32'h0000_5000, RESP_OKAY);
    go(16'h0065, 1'b1, 0, 20);
    go(16'h001F, 1'b0, 0, 20);
    wr_reg(ADDR_EXT8, 32'h0000_0032, RESP_OKAY);
    wr_reg(ADDR_CTRL, 32'h0000_6000, RESP_OKAY);
    go(16'h00C9, 1'b1, 0, 20);
    go(16'h0096, 1'b0, 0, 20);
    $display("Test external done");
  endtask : t_ext
  // Switch-on delay, switch-off without delay and a cancelled delay.
  task automatic t_delay();
    wr_reg(ADDR_DELAY, 32'h0000_0002, RESP_OKAY);
    wr_reg(ADDR_CTRL, 32'h0000_4000, RESP_OKAY);
    go(16'h0096, 1'b1, 20, 60);
    go(16'h0005, 1'b0, 0, 20);
    n0 = rxn;
    go(16'h0096, 1'b0, 0, 10);
    go(16'h0005, 1'b0, 0, 1);
    idle(60);
    chk("state_out", 0, 32'(st));
    chk("telegrams", 0, rxn - n0);
    $display("Test delay done");
  endtask : t_delay
  // Cyclic sending, then no sending at all.
  task automatic t_cyclic();
    wr_reg(ADDR_DELAY, 32'h0000_0000, RESP_OKAY);
    wr_reg(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    wr_reg(ADDR_CYCLE, 32'h0000_0001, RESP_OKAY);
    n0 = rxn;
    go(16'h0096, 1'b1, 0, 20);
    idle(226);
    chk("cyclic", 2, rxn - n0);
    chk("tx_bit", 1, 32'(rxl));
    wr_reg(ADDR_CYCLE, 32'h0000_0000, RESP_OKAY);
    idle(120);
    n0 = rxn;
    go(16'h0005, 1'b0, 0, 20);
    idle(230);
    chk("cyclic", 0, rxn - n0);
    $display("Test cyclic done");
  endtask : t_cyclic
  // A silent inactive condition keeps the state and suppresses cyclic telegrams.
  task automatic t_silent();
    wr_reg(ADDR_CTRL, 32'h0000_4400, RESP_OKAY);
    go(16'h0096, 1'b1, 0, 20);
    go(16'h0005, 1'b1, 0, 20);
    idle(20);
    chk("state_out", 1, 32'(st));
    wr_reg(ADDR_CYCLE, 32'h0000_0001, RESP_OKAY);
    n0 = rxn;
    idle(230);
    chk("telegrams", 0, rxn - n0);
    $display("Test silent done");
  endtask : t_silent
  initial
  begin
    {awv, wv, arv, awa, ara, wd, fail_count, compares} = '0;
    aresetn = 1'b0;
    ws = 16'h0000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_hyst();
    t_ext();
    t_delay();
    t_cyclic();
    t_silent();
    end_of_test();
  end
endmodule : ws2_monitor_tb_top
`default_nettype wire

// File: hdl/ws2_monitor.sv
// Wind speed threshold monitor with hysteresis, delays and telegram decisions.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ws2_monitor
  import ws2_pkg::*;
#(
  parameter int TICK_CYCLES  = TICK_CYCLES_DEF,
  parameter int RANGE_TENTHS = RANGE_TENTHS_DEF
) (
  input  wire logic        aclk,        // System clock, 125 MHz.
  input  wire logic        aresetn,     // Synchronous reset, active low.
  input  wire logic [15:0] wind_speed,  // Measured speed in 0.1 m/s.
  input  wire logic [7:0]  s_awaddr,    // Write address.
  input  wire logic        s_awvalid,   // Write address valid.
  output var  logic        s_awready,   // Write address ready.
  input  wire logic [31:0] s_wdata,     // Write data.
  input  wire logic [3:0]  s_wstrb,     // Write byte strobes.
  input  wire logic        s_wvalid,    // Write data valid.
  output var  logic        s_wready,    // Write data ready.
  output var  logic [1:0]  s_bresp,     // Write response.
  output var  logic        s_bvalid,    // Write response valid.
  input  wire logic        s_bready,    // Write response ready.
  input  wire logic [7:0]  s_araddr,    // Read address.
  input  wire logic        s_arvalid,   // Read address valid.
  output var  logic        s_arready,   // Read address ready.
  output var  logic [31:0] s_rdata,     // Read data.
  output var  logic [1:0]  s_rresp,     // Read response.
  output var  logic        s_rvalid,    // Read data valid.
  input  wire logic        s_rready,    // Read data ready.
  output var  logic        state_out,   // Accepted threshold state.
  output var  logic        tx_valid,    // One-cycle telegram strobe.
  output var  logic        tx_bit       // Telegram value.
);

  logic [31:0] ctrl_r, delay_r, cycle_r, ext16_r, ext8_r;
  logic [7:0]  aw_addr_r;
  logic        aw_hold_r, w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        active_r, pend_r, pend_val_r;
  logic [15:0] tx_cnt_r;
  logic        tick, dly_busy, dly_done, cyc_busy, cyc_done;

  // Merges write data into a register under the byte strobes.
  function automatic logic [31:0] ws2_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : ws2_merge

  // Configuration fields taken from the registers.
  logic [3:0]  cfg_thr, cfg_mode, cfg_on, cfg_off;
  logic [2:0]  cfg_hyst;
  logic [1:0]  cfg_ext;
  logic        cfg_chg;
  logic [7:0]  cfg_cycle;
  assign cfg_thr   = ctrl_r[CTRL_THR_LSB +: 4];
  assign cfg_hyst  = ctrl_r[CTRL_HYST_LSB +: 3];
  assign cfg_mode  = ctrl_r[CTRL_MODE_LSB +: 4];
  assign cfg_ext   = ctrl_r[CTRL_EXT_LSB +: 2];
  assign cfg_chg   = ctrl_r[CTRL_CHG_BIT];
  assign cfg_on    = delay_r[DLY_ON_LSB +: 4];
  assign cfg_off   = delay_r[DLY_OFF_LSB +: 4];
  assign cfg_cycle = cycle_r[7:0];

  // Threshold source: fixed step, two-byte value or percent of the range.
  logic [15:0] thr_fix, thr_pct, thr_eff, hyst;
  logic [31:0] pct_prod;
  assign thr_fix  = ws2_thr_step(cfg_thr);
  assign hyst     = ws2_hyst_step(cfg_hyst);
  assign pct_prod = (32'(ext8_r[7:0]) * 32'(RANGE_TENTHS)) / 32'h0000_0064;
  assign thr_pct  = pct_prod[15:0];
  always_comb
  begin
    if (cfg_ext == EXT_16)
    begin
      thr_eff = ext16_r[15:0];
    end
    else if (cfg_ext == EXT_8)
    begin
      thr_eff = thr_pct;
    end
    else
    begin
      thr_eff = thr_fix;
    end
  end

  // Mode decode and hysteresis bounds, widened so no bound wraps.
  logic [3:0]  mode_bits;
  logic        mode_und, mode_val, act_silent, inact_silent;
  logic [16:0] thr_lo, thr_hi;
  assign mode_bits    = ws2_mode(cfg_mode);
  assign mode_und     = mode_bits[3];
  assign mode_val     = mode_bits[2];
  assign act_silent   = mode_bits[1];
  assign inact_silent = mode_bits[0];
  assign thr_hi       = {1'b0, thr_eff} + {1'b0, hyst};
  assign thr_lo       = (thr_eff > hyst) ? {1'b0, thr_eff - hyst} : 17'h00000;

  // Condition flag: set on the first crossing, cleared past the hysteresis band.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active_r <= 1'b0;
    end
    else if (!mode_und)
    begin
      if (wind_speed > thr_eff)
      begin
        active_r <= 1'b1;
      end
      else if ({1'b0, wind_speed} < thr_lo)
      begin
        active_r <= 1'b0;
      end
    end
    else
    begin
      if (wind_speed < thr_eff)
      begin
        active_r <= 1'b1;
      end
      else if ({1'b0, wind_speed} > thr_hi)
      begin
        active_r <= 1'b0;
      end
    end
  end

  // Wanted state: a silent condition leaves the accepted state alone.
  logic silent_now, want;
  assign silent_now = active_r ? act_silent : inact_silent;
  assign want       = silent_now ? state_out : (active_r ? mode_val : !mode_val);

  // Delay timer control toward a new state.
  logic        dly_start, dly_cancel, chg_accept, chg_send;
  logic [11:0] dly_len;
  assign dly_start  = !pend_r && (want != state_out);
  assign dly_len    = want ? ws2_delay_s(cfg_on) : ws2_delay_s(cfg_off);
  assign dly_cancel = pend_r && (want != pend_val_r);
  assign chg_accept = pend_r && dly_done && !dly_cancel;
  assign chg_send   = chg_accept && cfg_chg;

  // Cyclic timer reloads with cycle times ten seconds; zero stops it.
  logic        cyc_start, cyc_stop, cyc_send;
  logic [11:0] cyc_len;
  assign cyc_len   = 12'(cfg_cycle) * 12'(CYCLE_STEP_S);
  assign cyc_stop  = (cfg_cycle == 8'h00);
  assign cyc_start = !cyc_busy && !cyc_stop;
  assign cyc_send  = cyc_done && !silent_now && !cyc_stop;

  // Second timebase shared by both timers.
  ws2_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // Switch-on and switch-off delay timer.
  ws2_sec_timer #(
    .W (12)
  ) u_dly (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (dly_start),
    .cancel  (dly_cancel),
    .len     (dly_len),
    .tick    (tick),
    .busy    (dly_busy),
    .done    (dly_done)
  );

  // Cyclic repeat timer.
  ws2_sec_timer #(
    .W (12)
  ) u_cyc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (cyc_start),
    .cancel  (cyc_stop),
    .len     (cyc_len),
    .tick    (tick),
    .busy    (cyc_busy),
    .done    (cyc_done)
  );

  // Pending change and accepted state; the old state holds while a delay runs.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_r     <= 1'b0;
      pend_val_r <= 1'b0;
      state_out  <= 1'b0;
    end
    else if (dly_start)
    begin
      pend_r     <= 1'b1;
      pend_val_r <= want;
    end
    else if (dly_cancel)
    begin
      pend_r <= 1'b0;
    end
    else if (chg_accept)
    begin
      pend_r    <= 1'b0;
      state_out <= pend_val_r;
    end
  end

  // Telegram strobe; a change and a cyclic send in one cycle give one telegram.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_valid <= 1'b0;
      tx_bit   <= 1'b0;
      tx_cnt_r <= 16'h0000;
    end
    else
    begin
      tx_valid <= chg_send || cyc_send;
      tx_bit   <= chg_send ? pend_val_r : state_out;
      if (chg_send || cyc_send)
      begin
        tx_cnt_r <= tx_cnt_r + 16'h0001;
      end
    end
  end

  // Write channel: address and data caught in either order, then one response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
      ctrl_r    <= CTRL_RST;
      delay_r   <= DELAY_RST;
      cycle_r   <= CYCLE_RST;
      ext16_r   <= EXT16_RST;
      ext8_r    <= EXT8_RST;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_addr_r <= s_awaddr;
        aw_hold_r <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
        w_hold_r <= 1'b1;
        s_wready <= 1'b0;
      end
      if (aw_hold_r && w_hold_r && !s_bvalid)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= RESP_OKAY;
        if (aw_addr_r == ADDR_CTRL)
        begin
          ctrl_r <= ws2_merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_7F7F;
        end
        else if (aw_addr_r == ADDR_DELAY)
        begin
          delay_r <= ws2_merge(delay_r, w_data_r, w_strb_r) & 32'h0000_0F0F;
        end
        else if (aw_addr_r == ADDR_CYCLE)
        begin
          cycle_r <= ws2_merge(cycle_r, w_data_r, w_strb_r) & 32'h0000_00FF;
        end
        else if (aw_addr_r == ADDR_EXT16)
        begin
          ext16_r <= ws2_merge(ext16_r, w_data_r, w_strb_r) & 32'h0000_FFFF;
        end
        else if (aw_addr_r == ADDR_EXT8)
        begin
          ext8_r <= ws2_merge(ext8_r, w_data_r, w_strb_r) & 32'h0000_00FF;
        end
        else if (aw_addr_r != ADDR_STATUS)
        begin
          s_bresp <= RESP_SLVERR;
        end
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answer one cycle after the address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= RESP_OKAY;
      if (s_araddr == ADDR_CTRL)
      begin
        s_rdata <= ctrl_r;
      end
      else if (s_araddr == ADDR_DELAY)
      begin
        s_rdata <= delay_r;
      end
      else if (s_araddr == ADDR_CYCLE)
      begin
        s_rdata <= cycle_r;
      end
      else if (s_araddr == ADDR_EXT16)
      begin
        s_rdata <= ext16_r;
      end
      else if (s_araddr == ADDR_EXT8)
      begin
        s_rdata <= ext8_r;
      end
      else if (s_araddr == ADDR_STATUS)
      begin
        s_rdata <= {tx_cnt_r, 10'h000, cyc_busy, dly_busy, pend_val_r, pend_r, active_r,
                    state_out};
      end
      else
      begin
        s_rdata <= 32'h0000_0000;
        s_rresp <= RESP_SLVERR;
      end
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Checks on the decision logic.
  chg_send_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chg_accept && cfg_chg |=> tx_valid && tx_bit == state_out)
    else $error("accepted change not sent");
  never_send_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_chg && cfg_cycle == 8'h00 |=> !tx_valid)
    else $error("telegram sent while sending is off");
  on_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_r && pend_val_r |-> !state_out)
    else $error("state not zero during on delay");
  off_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_r && !pend_val_r |-> state_out)
    else $error("state not one during off delay");
  delay_cancel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dly_cancel |=> !pend_r && state_out == $past(state_out))
    else $error("cancelled delay changed state");
  cyc_silent_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cyc_done && silent_now && !chg_send |=> !tx_valid)
    else $error("cyclic telegram in silent condition");
  cyc_send_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cyc_done && !silent_now |=> tx_valid ##1 !tx_valid)
    else $error("cyclic telegram missing");
  cyc_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_cycle == 8'h00 |=> !cyc_busy && !cyc_done)
    else $error("cyclic timer runs at cycle zero");
  exceed_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_und && wind_speed > thr_eff |=> active_r)
    else $error("exceed not detected");
  under_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_und && wind_speed < thr_eff |=> active_r)
    else $error("undershoot not detected");
  delay_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dly_start |=> pend_r && dly_busy && state_out == $past(state_out))
    else $error("delay did not start");

endmodule : ws2_monitor
`default_nettype wire

// File: hdl/ws2_pkg.sv
// Package with register map, field layout, timing counts and lookup tables of the monitor.
package ws2_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DELAY  = 8'h04;
  localparam logic [7:0] ADDR_CYCLE  = 8'h08;
  localparam logic [7:0] ADDR_EXT16  = 8'h0C;
  localparam logic [7:0] ADDR_EXT8   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Field positions in the control register.
  localparam int CTRL_THR_LSB  = 0;
  localparam int CTRL_HYST_LSB = 4;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_EXT_LSB  = 12;
  localparam int CTRL_CHG_BIT  = 14;

  // Field positions in the delay register.
  localparam int DLY_ON_LSB  = 0;
  localparam int DLY_OFF_LSB = 8;

  // Reset values of the writable registers.
  localparam logic [31:0] CTRL_RST  = 32'h0000_4000;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [31:0] CYCLE_RST = 32'h0000_0000;
  localparam logic [31:0] EXT16_RST = 32'h0000_0000;
  localparam logic [31:0] EXT8_RST  = 32'h0000_0000;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Threshold source selection.
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_16   = 2'h1;
  localparam logic [1:0] EXT_8    = 2'h2;

  // Timing: one second tick from the 8 ns clock, cyclic step of ten seconds.
  localparam int CLK_PERIOD_NS   = 8;
  localparam int SEC_NS          = 1_000_000_000;
  localparam int TICK_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int CYCLE_STEP_S    = 10;

  // Upper range value of the speed input in 0.1 m/s, used for percent thresholds.
  localparam int RANGE_TENTHS_DEF = 400;

  // Fixed threshold steps in 0.1 m/s.
  function automatic logic [15:0] ws2_thr_step(input logic [3:0] idx);
    case (idx)
      4'h0:    ws2_thr_step = 16'h000A;
      4'h1:    ws2_thr_step = 16'h001E;
      4'h2:    ws2_thr_step = 16'h0032;
      4'h3:    ws2_thr_step = 16'h0050;
      4'h4:    ws2_thr_step = 16'h0064;
      4'h5:    ws2_thr_step = 16'h0078;
      4'h6:    ws2_thr_step = 16'h0096;
      4'h7:    ws2_thr_step = 16'h00C8;
      4'h8:    ws2_thr_step = 16'h00DC;
      4'h9:    ws2_thr_step = 16'h00FA;
      4'hA:    ws2_thr_step = 16'h012C;
      default: ws2_thr_step = 16'h015E;
    endcase
  endfunction : ws2_thr_step

  // Hysteresis steps in 0.1 m/s.
  function automatic logic [15:0] ws2_hyst_step(input logic [2:0] idx);
    case (idx)
      3'h0:    ws2_hyst_step = 16'h0000;
      3'h1:    ws2_hyst_step = 16'h000A;
      3'h2:    ws2_hyst_step = 16'h001E;
      3'h3:    ws2_hyst_step = 16'h0032;
      3'h4:    ws2_hyst_step = 16'h0050;
      default: ws2_hyst_step = 16'h0064;
    endcase
  endfunction : ws2_hyst_step

  // Delay choices in seconds.
  function automatic logic [11:0] ws2_delay_s(input logic [3:0] idx);
    case (idx)
      4'h0:    ws2_delay_s = 12'h000;
      4'h1:    ws2_delay_s = 12'h001;
      4'h2:    ws2_delay_s = 12'h003;
      4'h3:    ws2_delay_s = 12'h005;
      4'h4:    ws2_delay_s = 12'h00A;
      4'h5:    ws2_delay_s = 12'h00F;
      4'h6:    ws2_delay_s = 12'h01E;
      4'h7:    ws2_delay_s = 12'h03C;
      4'h8:    ws2_delay_s = 12'h0B4;
      4'h9:    ws2_delay_s = 12'h12C;
      4'hA:    ws2_delay_s = 12'h258;
      4'hB:    ws2_delay_s = 12'h384;
      4'hC:    ws2_delay_s = 12'h708;
      default: ws2_delay_s = 12'hE10;
    endcase
  endfunction : ws2_delay_s

  // Mode decode: {undershoot based, value when active, active silent, inactive silent}.
  function automatic logic [3:0] ws2_mode(input logic [3:0] idx);
    case (idx)
      4'h0:    ws2_mode = 4'b0100;
      4'h1:    ws2_mode = 4'b0000;
      4'h2:    ws2_mode = 4'b1100;
      4'h3:    ws2_mode = 4'b1000;
      4'h4:    ws2_mode = 4'b0101;
      4'h5:    ws2_mode = 4'b0001;
      4'h6:    ws2_mode = 4'b1101;
      4'h7:    ws2_mode = 4'b1001;
      4'h8:    ws2_mode = 4'b0110;
      4'h9:    ws2_mode = 4'b0010;
      4'hA:    ws2_mode = 4'b1110;
      default: ws2_mode = 4'b1010;
    endcase
  endfunction : ws2_mode

endpackage : ws2_pkg

// File: hdl/ws2_sec_timer.sv
// Seconds timer with load, cancel and a done pulse.
`timescale 1ns/100ps
`default_nettype none
module ws2_sec_timer #(
  parameter int W = 12
) (
  input  wire logic         aclk,     // System clock.
  input  wire logic         aresetn,  // Synchronous reset, active low.
  input  wire logic         start,    // Load length and run.
  input  wire logic         cancel,   // Stop without done.
  input  wire logic [W-1:0] len,      // Length in seconds.
  input  wire logic         tick,     // One second pulse.
  output var  logic         busy,     // Timer running.
  output var  logic         done      // One-cycle pulse at expiry.
);

  logic [W-1:0] cnt_r;

  // Cancel beats expiry; a zero length expires on the next cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cancel)
    begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else if (start && !busy)
    begin
      cnt_r <= len;
      busy  <= 1'b1;
      done  <= 1'b0;
    end
    else if (busy && cnt_r == '0)
    begin
      busy <= 1'b0;
      done <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      if (busy && tick)
      begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

endmodule : ws2_sec_timer
`default_nettype wire

// File: hdl/ws2_tick_gen.sv
// One second tick generator derived from the system clock.
`timescale 1ns/100ps
`default_nettype none
module ws2_tick_gen #(
  parameter int TICK_CYCLES = 125_000_000
) (
  input  wire logic aclk,     // System clock.
  input  wire logic aresetn,  // Synchronous reset, active low.
  output var  logic tick      // One-cycle pulse once per second.
);

  logic [31:0] cnt_r;

  // Counts clock cycles and pulses when a full second has passed.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b0;
    end
    else if (cnt_r == 32'(TICK_CYCLES - 1))
    begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end

endmodule : ws2_tick_gen
`default_nettype wire
